/* File: rpf_filter.sv */
`timescale 1ns/10ps
module rpf_filter #(
    parameter int CW = 5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic tick,
    input wire logic [CW-1:0] limit,
    // Data
    input wire logic din,
    output logic dout,
    output logic [CW-1:0] cnt
);
    import rpf_pkg::*;

    if (CW < 1)
    begin : g_bad_cw
        $error("rpf_filter: CW must be at least 1.");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic out;
    } rpf_filt_state_t;

    rpf_filt_state_t st;
    rpf_filt_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (clr)
        begin
            next_st.cnt = '0;
            next_st.out = din;
        end
        else if (tick)
        begin
            // The output follows only after limit+1 ticks in a row on which din differs from it.
            if (din == st.out)
            begin
                next_st.cnt = '0;
            end
            else if (st.cnt == limit)
            begin
                next_st.out = din;
                next_st.cnt = '0;
            end
            else
            begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dout = st.out;
    assign cnt = st.cnt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_filt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clr |=> (cnt == '0) && (dout == $past(din)))
        else $error("Filter state not cleared.");

    a_filt_settle: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(dout) && !$past(clr)) |->
            ($past(tick) && ($past(cnt) == $past(limit)) && ($past(din) == dout)))
        else $error("Filter output changed before its count.");

endmodule : rpf_filter

/* File: rpf_pin_board.sv */
`timescale 1ns/10ps
module rpf_pin_board (
    // Clock
    input wire logic pclk,
    // Board reset pin
    output logic reset_pin_n
);
    // The board pulls the pin up, so a released pin reads high.
    initial reset_pin_n = 1'b1;

    task automatic pulse(input int len);
        reset_pin_n <= 1'b0;
        repeat (len) @(posedge pclk);
        reset_pin_n <= 1'b1;
    endtask : pulse
endmodule : rpf_pin_board

/* File: rpf_pkg.sv */
package rpf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h004;
    localparam logic [ADDR_W-1:0] WIDTH_INDEX = 12'h005;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] WIDTH_ADDR = {WIDTH_INDEX[ADDR_W-3:0], 2'h0};

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int SS_BIT = 2;
    localparam int RW_LSB = 0;
    localparam int RW_W = 2;
    localparam int FW_W = 5;
    localparam logic SS_RST = 1'h0;
    localparam logic [RW_W-1:0] RW_RST = 2'h0;
    localparam logic [FW_W-1:0] FW_RST = 5'h00;
    localparam logic [RW_W-1:0] RW_NONE = 2'h0;
    localparam logic [RW_W-1:0] RW_BUS = 2'h1;
    localparam logic [RW_W-1:0] RW_OSC = 2'h2;
    localparam int OSC_COUNT_DEFAULT = 3;
    localparam int SYNC_W = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEL_NONE, SEL_BUS, SEL_OSC} rpf_sel_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } rpf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rpf_apb_rsp_t;

    typedef struct packed {
        logic [SYNC_W-1:0] sync;
        logic pin_asserted;
        logic stop_ss;
        logic [RW_W-1:0] run_rw;
        logic [FW_W-1:0] fw;
        logic stop_d;
        logic filt_rst;
        logic [7:0] rdata;
        logic slverr;
    } rpf_state_t;

endpackage : rpf_pkg

/* File: rpf_top.sv */
`timescale 1ns/10ps
// How it works
// - Filter select bits reset only on power-on reset, survive every other reset.
// - Bus clock filter cleared when disabled and on entry to stop mode.
// - Oscillator filter cleared only when disabled or on warm reset, not by stop entry.
// - Stop select bit: 0 no filtering, 1 oscillator filter in stop modes.
// - Run select 00 none, 01 bus clock, 10 oscillator, 11 reserved.
// - Bus filter count equals width field plus one, 1 to 32.
// - Width field resets only on power-on reset.
// - Unused upper bits of both registers read zero and ignore writes.
module rpf_top #(
    parameter int OSC_COUNT = rpf_pkg::OSC_COUNT_DEFAULT
) (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire rpf_pkg::rpf_apb_req_t apb_req,
    output rpf_pkg::rpf_apb_rsp_t apb_rsp,
    // System state
    input wire logic warm_reset,
    input wire logic stop_mode,
    input wire logic osc_tick,
    // Reset pin and result
    input wire logic reset_pin_n,
    output logic filtered_reset
);
    import rpf_pkg::*;

    if (OSC_COUNT < 1 || OSC_COUNT > 32)
    begin : g_bad_osc
        $error("rpf_top: OSC_COUNT must lie in 1 to 32.");
    end

    // The oscillator count is fixed at build time, as no register selects it.
    localparam logic [FW_W-1:0] OSC_LIMIT = FW_W'(OSC_COUNT - 1);

    // ------------------------------------------------------------
    // Select decoding
    // ------------------------------------------------------------
    function automatic rpf_sel_t rpf_select(input logic stop, input logic ss,
                                            input logic [RW_W-1:0] rw);
        rpf_sel_t s;
        s = SEL_NONE;
        if (stop)
        begin
            s = ss ? SEL_OSC : SEL_NONE;
        end
        else if (rw == RW_BUS)
        begin
            s = SEL_BUS;
        end
        else if (rw == RW_OSC)
        begin
            s = SEL_OSC;
        end
        return s;
    endfunction : rpf_select

    rpf_state_t st;
    rpf_state_t next_st;
    rpf_sel_t sel;
    logic bus_clr;
    logic osc_clr;
    logic bus_out;
    logic osc_out;
    logic [FW_W-1:0] bus_cnt;
    logic [FW_W-1:0] osc_cnt;
    logic wr_access;

    assign sel = rpf_select(stop_mode, st.stop_ss, st.run_rw);
    // Stop entry flushes the bus filter since its clock is gated off there.
    assign bus_clr = (sel != SEL_BUS) || (stop_mode && !st.stop_d) || warm_reset;
    assign osc_clr = (sel != SEL_OSC) || warm_reset;
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite && !st.slverr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[SYNC_W-2:0], ~reset_pin_n};
        if (st.sync[1] == st.sync[2])
        begin
            next_st.pin_asserted = st.sync[2];
        end
        next_st.stop_d = stop_mode;
        if (apb_req.psel && !apb_req.penable)
        begin
            if (apb_req.paddr == CTRL_ADDR)
            begin
                next_st.rdata = {5'h00, st.stop_ss, st.run_rw};
                next_st.slverr = 1'b0;
            end
            else if (apb_req.paddr == WIDTH_ADDR)
            begin
                next_st.rdata = {3'h0, st.fw};
                next_st.slverr = 1'b0;
            end
            else
            begin
                next_st.rdata = 8'h00;
                next_st.slverr = 1'b1;
            end
        end
        // Warm resets never reach the configuration; only presetn does.
        if (wr_access && apb_req.paddr == CTRL_ADDR)
        begin
            next_st.stop_ss = apb_req.pwdata[SS_BIT];
            next_st.run_rw = apb_req.pwdata[RW_LSB +: RW_W];
        end
        else if (wr_access && apb_req.paddr == WIDTH_ADDR)
        begin
            next_st.fw = apb_req.pwdata[FW_W-1:0];
        end
        case (sel)
            SEL_BUS: next_st.filt_rst = bus_out;
            SEL_OSC: next_st.filt_rst = osc_out;
            default: next_st.filt_rst = st.pin_asserted;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.stop_ss <= SS_RST;
            st.run_rw <= RW_RST;
            st.fw <= FW_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Filters
    // ------------------------------------------------------------
    rpf_filter #(.CW(FW_W)) u_bus_filter (
        .pclk(pclk),
        .presetn(presetn),
        .clr(bus_clr),
        .tick(1'b1),
        .limit(st.fw),
        .din(st.pin_asserted),
        .dout(bus_out),
        .cnt(bus_cnt)
    );

    rpf_filter #(.CW(FW_W)) u_osc_filter (
        .pclk(pclk),
        .presetn(presetn),
        .clr(osc_clr),
        .tick(osc_tick),
        .limit(OSC_LIMIT),
        .din(st.pin_asserted),
        .dout(osc_out),
        .cnt(osc_cnt)
    );

    assign apb_rsp.prdata = {24'h000000, st.rdata};
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = st.slverr;
    assign filtered_reset = st.filt_rst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ctrl_warm_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (warm_reset && !wr_access) |=> ($stable(st.stop_ss) && $stable(st.run_rw)))
        else $error("Control select changed on warm reset.");

    a_width_warm_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (warm_reset && !wr_access) |=> $stable(st.fw))
        else $error("Width field changed on warm reset.");

    a_ctrl_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_req.psel && apb_req.penable && apb_req.paddr == CTRL_ADDR)
            |-> (apb_rsp.prdata[31:3] == 29'h0) && !apb_rsp.pslverr)
        else $error("Control reserved bits not zero.");

    a_width_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_req.psel && apb_req.penable && apb_req.paddr == WIDTH_ADDR)
            |-> (apb_rsp.prdata[31:5] == 27'h0) && (apb_rsp.prdata[4:0] == st.fw))
        else $error("Width readback wrong.");

    a_bus_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !st.stop_d) |=> (bus_cnt == '0))
        else $error("Bus filter kept state across stop entry.");

    a_osc_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(stop_mode) && sel == SEL_OSC && $past(sel) == SEL_OSC
            && !osc_tick && !warm_reset) |=> (osc_cnt == $past(osc_cnt)))
        else $error("Oscillator filter cleared by stop entry.");

    a_rw_rsvd_none: assert property (@(posedge pclk) disable iff (!presetn)
        (!stop_mode && st.run_rw == 2'h3) |=> (filtered_reset == $past(st.pin_asserted)))
        else $error("Reserved run select did not bypass.");

    a_stop_off_none: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !st.stop_ss) |=> (filtered_reset == $past(st.pin_asserted)))
        else $error("Stop mode filtering not bypassed.");

    a_bus_width: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(bus_out) && !$past(bus_clr)) |-> ($past(bus_cnt) == $past(st.fw)))
        else $error("Bus filter width wrong.");

    a_osc_width: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(osc_out) && !$past(osc_clr))
            |-> ($past(osc_tick) && ($past(osc_cnt) == OSC_LIMIT)))
        else $error("Oscillator filter count wrong.");

    a_bus_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sel != SEL_BUS) |=> (bus_cnt == '0))
        else $error("Bus filter not cleared while disabled.");

    a_osc_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sel != SEL_OSC) |=> (osc_cnt == '0))
        else $error("Oscillator filter not cleared while disabled.");

endmodule : rpf_top

/* File: test_reset_pin_glitch_filter.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module test_reset_pin_glitch_filter;
    import rpf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    rpf_apb_req_t apb_req = '0;
    rpf_apb_rsp_t apb_rsp;
    logic warm_reset = 1'b0;
    logic stop_mode = 1'b0;
    logic osc_tick = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic reset_pin_n;
    logic filtered_reset;
    logic [31:0] q;
    logic e;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 32'hd8b0;
    int w, lat, lat0, i;
    logic [3:0] mode_pass = 4'b1001;

    // ------------------------------------------------------------
    // Clock, oscillator tick and hang guard
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        osc_div <= osc_div + 2'h1;
        osc_tick <= (osc_div == 2'h3);
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end

    rpf_pin_board pin (.pclk(pclk), .reset_pin_n(reset_pin_n));

    rpf_top #(.OSC_COUNT(3)) DUT (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .warm_reset(warm_reset), .stop_mode(stop_mode), .osc_tick(osc_tick),
        .reset_pin_n(reset_pin_n), .filtered_reset(filtered_reset)
    );

    // ------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // Only the bench-wide cycle ceiling ends a wait that never completes.
        do
        begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // Drives one low pulse and reports whether the output asserted and how soon.
    task automatic try_pulse(input int len, input logic exp);
        int k;
        lat = -1;
        // Start on a rising edge so that every latency is counted from the same phase.
        @(posedge pclk);
        fork
            pin.pulse(len);
            for (k = 0; k < len + 70; k++)
            begin
                @(negedge pclk);
                if (filtered_reset === 1'b1 && lat < 0)
                    lat = k;
            end
        join
        `CHK(lat >= 0, exp)
        `CHK(filtered_reset, 1'b0)
    endtask : try_pulse

    // A pulse gets through a filter only if it lasts at least the filter count.
    function automatic logic accepted(input int len, input int count);
        return (len >= count);
    endfunction : accepted

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, WIDTH_ADDR, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, CTRL_ADDR, 32'hffffffff);
        apb(1'b1, WIDTH_ADDR, 32'hffffffff);
        apb(1'b0, 12'h018, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        @(posedge pclk);
        warm_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        warm_reset <= 1'b0;
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK({e, q}, {1'b0, 32'h7})
        apb(1'b0, WIDTH_ADDR, 32'h0);
        `CHK(q, 32'h1f)
        try_pulse(3, 1'b1);
        // Bus clock filter: latency grows by exactly one cycle per width step.
        apb(1'b1, WIDTH_ADDR, 32'h0);
        apb(1'b1, CTRL_ADDR, {30'h0, RW_BUS});
        try_pulse(6, 1'b1);
        lat0 = lat;
        for (i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 1 : (i == 1) ? 31 : 1 + ($unsigned($random(seed)) % 30);
            apb(1'b1, WIDTH_ADDR, w);
            try_pulse(w, accepted(w, w + 1));
            try_pulse(w + 6, accepted(w + 6, w + 1));
            `CHK(lat - lat0, w)
        end
        // Every run select code, short glitch against count 11 and long pulse.
        apb(1'b1, WIDTH_ADDR, 32'ha);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, CTRL_ADDR, i);
            try_pulse(6, mode_pass[i]);
            try_pulse(40, 1'b1);
        end
        // Stop entry in mid-glitch must leave the oscillator filter counting.
        apb(1'b1, CTRL_ADDR, {29'h0, 1'b1, RW_OSC});
        fork
            try_pulse(6, 1'b0);
            begin
                repeat (6) @(posedge pclk);
                stop_mode <= 1'b1;
            end
        join
        // Stop modes with the bus filter selected for run, then run mode and power-on reset.
        apb(1'b1, CTRL_ADDR, {30'h0, RW_BUS});
        try_pulse(6, 1'b1);
        apb(1'b1, CTRL_ADDR, {29'h0, 1'b1, RW_BUS});
        try_pulse(6, 1'b0);
        try_pulse(40, 1'b1);
        @(posedge pclk);
        stop_mode <= 1'b0;
        apb(1'b1, CTRL_ADDR, {30'h0, RW_BUS});
        try_pulse(6, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, WIDTH_ADDR, 32'h0);
        `CHK(q, 32'h0)
        report_and_stop();
    end
endmodule : test_reset_pin_glitch_filter
